// ---- tb.sv ----
// self-checking bench for the receive watchdog and wake-up filter
// assumes uwd_master_model on the receive side; inputs change at the falling edge
`timescale 1ns/100ps
module tb import uwd_pkg::*; ;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic rxq_ready = 1'b1, global_read = 1'b0;
  logic [1:0] ctx = 2'h0;
  logic [3:0] chan_read = '0, tick_v = '0, wd_en = '0, wd_ctl = '0, mask6 = '0, bid_en = 4'hf;
  logic [3:0] mask5 = '0, en_cmd = '0, dis_cmd = '0, rx_rst = '0, a_clr = '0;
  logic [6:0] thr = 7'h2a;
  logic [3:0][3:0] cnt = {4'h7, 4'h7, 4'h2, 4'h3};
  logic [3:0][7:0] m0 = '0, m1 = '0, sta = {8'h00, 8'h00, 8'h42, 8'h00};
  logic [3:0][2:0] lvl = {3'h0, 3'h0, 3'h5, 3'h0};
  logic rx_valid, rx_ad, rx_ready, push, rr_flag, r_only, win_v;
  logic [1:0] rx_chan, q_chan, win_c;
  logic [7:0] rx_data, q_data;
  logic [2:0] rx_err;
  logic [3:0] q_stat, st6, st5, airq, act, txad;
  logic [6:0] thr_o;
  logic [3:0][9:0] abid;
  logic [13:0] last_w = '0;
  int bad_count = 0, total_checks = 0, push_n = 0, cyc = 0, n = 0;

  // 100 MHz clock
  always #5 clk_i = ~clk_i;

  uwd_master_model MST (.clk_i(clk_i), .rx_ready_i(rx_ready), .rx_valid_o(rx_valid), .rx_chan_o(rx_chan),
    .rx_data_o(rx_data), .rx_ad_flag_o(rx_ad), .rx_err_o(rx_err));

  uwd_rx_watch DUT (.clk_i(clk_i), .rst_i(rst_i), .rx_valid_i(rx_valid), .rx_ready_o(rx_ready),
    .rx_chan_i(rx_chan), .rx_data_i(rx_data), .rx_ad_flag_i(rx_ad), .rx_err_i(rx_err), .rxq_push_o(push),
    .rxq_ready_i(rxq_ready), .rxq_chan_o(q_chan), .rxq_data_o(q_data), .rxq_status_o(q_stat),
    .receive_ready_flag_o(rr_flag), .chan_read_i(chan_read), .global_read_i(global_read),
    .int_ctx_chan_i(ctx), .bit_tick_i(tick_v), .rx_timeout_enable_i(wd_en), .rx_timeout_control_i(wd_ctl),
    .interrupt_mask_6_i(mask6), .interrupt_status_6_o(st6), .receiver_only_o(r_only),
    .interrupt_threshold_i(thr), .threshold_o(thr_o), .rx_bid_en_i(bid_en), .rx_count_i(cnt),
    .rx_win_valid_o(win_v), .rx_win_chan_o(win_c), .mode_control_0_i(m0), .mode_control_1_i(m1),
    .station_address_char_i(sta), .address_event_bid_level_i(lvl), .interrupt_mask_5_i(mask5),
    .rx_enable_cmd_i(en_cmd), .rx_disable_cmd_i(dis_cmd), .rx_reset_i(rx_rst), .addr_clear_i(a_clr),
    .interrupt_status_5_o(st5), .addr_irq_o(airq), .addr_bid_o(abid), .rx_active_o(act),
    .tx_ad_flag_o(txad));

  // push monitor; receive_ready must pulse with every push
  always @(posedge clk_i) begin
    cyc++;
    if (push === 1'b1) begin
      push_n++;
      last_w <= {q_chan, q_data, q_stat};
    end
    if (push !== rr_flag) check(rr_flag, push);
    if (cyc == 6000) begin
      bad_count++;
      results();
    end
  end

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask : check

  task automatic results;
    $display("checks=%0d mismatches=%0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : results

  task automatic step(input int k);
    repeat (k) @(negedge clk_i);
  endtask : step

  // one bit-time tick pulse per channel in m, k times
  task automatic tick(input logic [3:0] m, input int k);
    repeat (k) begin
      tick_v = m;
      step(1);
      tick_v = 4'h0;
      step(1);
    end
  endtask : tick

  // one character, then long enough for an empty queue to deliver it
  task automatic put(input logic [1:0] ch, input logic [7:0] d, input logic ad, input logic [2:0] e);
    MST.send(ch, d, ad, e, 0);
    step(3);
  endtask : put

  initial begin
    step(8);
    rst_i = 1'b0;
    check(st6, 4'h0);
    check(act, 4'h0);
    check(rx_ready, 1'b1);
    // only ch0 has both enable bits
    wd_en = 4'h3; wd_ctl = 4'h9; mask6 = 4'h1;
    tick(4'hb, 63);
    check(st6, 4'h0);
    tick(4'hb, 1);
    check(st6, 4'h1);
    check(r_only, 1'b1);
    check(thr_o, 7'h00);
    step(1);
    check({win_v, win_c}, 3'h7);
    bid_en = 4'h7;
    step(2);
    check({win_v, win_c}, 3'h6);
    mask6 = 4'h0;
    step(1);
    check({r_only, thr_o, st6, win_v}, {1'b0, 7'h2a, 4'h1, 1'b0});
    mask6 = 4'h1;
    chan_read = 4'h1; step(1); chan_read = 4'h0; step(1);
    check({st6, thr_o}, {4'h0, 7'h2a});
    // global read clears only the context channel
    wd_ctl = 4'hf;
    tick(4'h3, 64);
    check(st6, 4'h3);
    ctx = 2'h1; global_read = 1'b1; step(1); global_read = 1'b0; step(1);
    check(st6, 4'h1);
    ctx = 2'h0; global_read = 1'b1; step(1); global_read = 1'b0; step(1);
    check(st6, 4'h0);
    tick(4'h1, 40);
    chan_read = 4'h1; step(1); chan_read = 4'h0; step(1);
    tick(4'h1, 63);
    check(st6, 4'h0);
    tick(4'h1, 1);
    n = push_n;
    put(2'h0, 8'h77, 1'b0, 3'h2);
    check({push_n - n, st6}, {32'd1, 4'h0});
    check(last_w, {2'h0, 8'h77, 4'h4});
    tick(4'h1, 64);
    wd_en = 4'h0; step(1); wd_en = 4'h1; step(1);
    check(st6, 4'h0);
    tick(4'h1, 63);
    check(st6, 4'h0);
    wd_en = 4'h0;
    // host-controlled wake-up on ch2, transmit flag set before any character
    m1[2] = 8'h1c; step(1);
    check({act[2], txad}, 5'h14);
    m1[2] = 8'h18; step(1);
    check(txad, 4'h0);
    n = push_n;
    put(2'h2, 8'h55, 1'b0, 3'h0);
    check(push_n - n, 0);
    put(2'h2, 8'ha5, 1'b1, 3'h5);
    check({push_n - n, last_w}, {32'd1, 2'h2, 8'ha5, 4'hb});
    en_cmd = 4'h4; step(1); en_cmd = 4'h0;
    put(2'h2, 8'h3c, 1'b0, 3'h0);
    check(last_w, {2'h2, 8'h3c, 4'h0});
    // stall the drain until the queue refuses, then release
    rxq_ready = 1'b0;
    n = push_n;
    for (int i = 0; i < 4; i++) put(2'h2, 8'h10 + 8'(i), 1'b1, 3'h0);
    check({push_n - n, rx_ready}, {32'd0, 1'b0});
    rxq_ready = 1'b1;
    step(10);
    check({push_n - n, rx_ready, last_w}, {32'd4, 1'b1, 2'h2, 8'h13, 4'h1});
    dis_cmd = 4'h4; step(1); dis_cmd = 4'h0;
    put(2'h2, 8'h66, 1'b0, 3'h0);
    check(push_n - n, 4);
    // auto wake on ch1, address dropped
    m1[1] = 8'h18; m0[1] = 8'h01; mask5 = 4'h2;
    n = push_n;
    put(2'h1, 8'h42, 1'b1, 3'h0);
    check({push_n - n, st5, airq}, {32'd0, 8'h22});
    check(abid[1], {3'h5, ADDR_CODE, 3'h1});
    mask5 = 4'h0; step(1);
    check(airq, 4'h0);
    a_clr = 4'h2; step(1); a_clr = 4'h0; step(1);
    check(st5, 4'h0);
    put(2'h1, 8'h11, 1'b0, 3'h0);
    check({push_n - n, last_w}, {32'd1, 2'h1, 8'h11, 4'h0});
    // auto doze with address push
    m0[1] = 8'h42;
    put(2'h1, 8'h99, 1'b1, 3'h0);
    check({push_n - n, last_w}, {32'd2, 2'h1, 8'h99, 4'h1});
    put(2'h1, 8'h12, 1'b0, 3'h0);
    check(push_n - n, 2);
    // wake and doze together
    m0[1] = 8'h43;
    put(2'h1, 8'h42, 1'b1, 3'h0);
    put(2'h1, 8'h13, 1'b0, 3'h0);
    check({push_n - n, last_w}, {32'd4, 2'h1, 8'h13, 4'h0});
    // receiver reset drops the enable and the event, address watch stays alive
    rx_rst = 4'h2; step(1); rx_rst = 4'h0; step(1);
    check({st5, act[1]}, 5'h01);
    put(2'h1, 8'h42, 1'b1, 3'h0);
    check({push_n - n, st5}, {32'd5, 4'h2});
    results();
  end
endmodule : tb

// ---- uwd_fifo.sv ----
// small flop-based fifo with valid/ready on both sides
// assumes one clock and a synchronous active-high reset
`timescale 1ns/100ps
module uwd_fifo #(
  parameter int unsigned W = 14,
  parameter int unsigned D = 4
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [W-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [W-1:0] out_data_o
);
  localparam int unsigned AW = $clog2(D);

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } uwd_fifo_st_t;

  uwd_fifo_st_t f_q;
  uwd_fifo_st_t f_d;
  logic wr;
  logic rd;

  // handshakes are combinational, data comes straight from the storage flops
  assign in_ready_o = f_q.cnt != (AW+1)'(D);
  assign out_valid_o = f_q.cnt != '0;
  assign out_data_o = f_q.mem[f_q.rp];
  assign wr = in_valid_i & in_ready_o;
  assign rd = out_valid_o & out_ready_i;

  // pointer wrap relies on a power of two depth
  always_comb begin
    f_d = f_q;
    if (wr) begin
      f_d.mem[f_q.wp] = in_data_i;
      f_d.wp = AW'(f_q.wp + 1'b1);
    end
    if (rd) begin
      f_d.rp = AW'(f_q.rp + 1'b1);
    end
    f_d.cnt = (AW+1)'(f_q.cnt + {{AW{1'b0}}, wr} - {{AW{1'b0}}, rd});
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      f_q <= '0;
    end else begin
      f_q <= f_d;
    end
  end

endmodule : uwd_fifo

// ---- uwd_master_model.sv ----
// remote master station model offering received characters to the block
// assumes the bench clock; lines change only at the falling edge
`timescale 1ns/100ps
module uwd_master_model (
  input wire logic clk_i,
  input wire logic rx_ready_i,
  output logic rx_valid_o,
  output logic [1:0] rx_chan_o,
  output logic [7:0] rx_data_o,
  output logic rx_ad_flag_o,
  output logic [2:0] rx_err_o
);
  // idle lines at time zero
  initial begin
    rx_valid_o = 1'b0;
    rx_chan_o = 2'h0;
    rx_data_o = 8'h00;
    rx_ad_flag_o = 1'b0;
    rx_err_o = 3'h0;
  end

  // one character after gap cycles, held until taken; lines are then inverted
  // so a late sample never sees a stale copy
  task automatic send(input logic [1:0] ch, input logic [7:0] d, input logic ad, input logic [2:0] e,
                      input int gap);
    repeat (gap + 1) @(negedge clk_i);
    rx_valid_o = 1'b1;
    rx_chan_o = ch;
    rx_data_o = d;
    rx_ad_flag_o = ad;
    rx_err_o = e;
    @(posedge clk_i);
    // a stuck queue is caught by the bench cycle ceiling, not dropped here
    while (rx_ready_i !== 1'b1) begin
      @(posedge clk_i);
    end
    @(negedge clk_i);
    rx_valid_o = 1'b0;
    rx_chan_o = ~ch;
    rx_data_o = ~d;
    rx_ad_flag_o = ~ad;
    rx_err_o = ~e;
  endtask : send
endmodule : uwd_master_model

// ---- uwd_pkg.sv ----
// constants and state type for the receive watchdog and multidrop wake-up block
// assumes a four channel receiver core and a host register file outside this block
package uwd_pkg;

  // channel count and per-channel field widths
  localparam int unsigned NCH = 4;
  localparam int unsigned CNT_W = 7;
  localparam logic [CNT_W-1:0] WD_LIMIT = 7'h40; // 64 bit times
  localparam logic [CNT_W-1:0] CNT_RST = 7'h00;

  // mode_control_1 field positions and the wake-up select value
  localparam int unsigned M1_WAKE_HI = 4;
  localparam int unsigned M1_WAKE_LO = 3;
  localparam int unsigned M1_TXAD = 2;
  localparam logic [1:0] WAKE_SEL = 2'h3;

  // mode_control_0 field positions
  localparam int unsigned M0_ADDR_PUSH = 6;
  localparam int unsigned M0_DOZE = 1;
  localparam int unsigned M0_WAKE = 0;

  // address recognition bid source code
  localparam logic [3:0] ADDR_CODE = 4'h3;

  // receive word layout: chan, data, a/d or parity, break, overrun, framing
  localparam int unsigned W_CHAN = 12;
  localparam int unsigned W_DATA = 4;
  localparam int unsigned W_AD = 3;
  localparam int unsigned W_ERR = 0;
  localparam int unsigned WORD_W = 14;
  localparam int unsigned FIFO_DEPTH = 4;

  // whole block state, registered as one value
  typedef struct packed {
    logic [NCH-1:0][CNT_W-1:0] cnt;
    logic [NCH-1:0] bark;
    logic [NCH-1:0] rx_en;
    logic [NCH-1:0] addr_ev;
    logic push;
    logic [1:0] chan;
    logic [7:0] data;
    logic [3:0] stat;
    logic [1:0] win;
    logic win_v;
  } uwd_state_t;

  localparam uwd_state_t STATE_RST = '0;

endpackage : uwd_pkg

// ---- uwd_rx_watch.sv ----
// per-channel receive watchdog and multidrop wake-up filter for four channels
// assumes the receiver core, the host registers and the arbiter sit outside on clk_i
// Summary of operation
// - watchdog times out after 64 receiver bit ticks without queue activity.
// - count restarts on channel read, global read or character push.
// - global read restarts only the watchdog of the current interrupt channel.
// - a watchdog counts only while both its timeout enable and timeout control bits are set.
// - timeout reaches arbiter only with mask bit 6; status bit 6 shows it.
// - pending timeout admits receivers only, ignores threshold, fullest receiver wins.
// - timeout clears on next push or read, then threshold arbitration resumes.
// - wake-up operation is selected by mode_control_1 bits 4:3 equal 11.
// - submode 00 host, 01 auto wake, 10 auto doze, 11 both.
// - parity position carries address/data flag, one address, zero data.
// - wake-up keeps address monitoring alive while the receiver is off.
// - transmit address/data flag follows mode_control_1 bit 2.
// - host mode, disabled receiver stores only addresses, drops data.
// - enabled receiver in wake-up stores every data character.
// - received address/data flag fills the parity error status slot.
// - framing, overrun and break status pass through unchanged.
// - auto submodes push address characters only when mode_control_0 bit 6 set.
// - auto wake: matching address enables the receiver.
// - auto doze: non-matching address disables the receiver.
// - address event gated by mask bit 5, bid level from its register.
// - channel number in bid low field, highest channel wins ties.
`timescale 1ns/100ps
module uwd_rx_watch import uwd_pkg::*; (
  input wire logic clk_i,
  input wire logic rst_i,
  // character push from the receiver core
  input wire logic rx_valid_i,
  output logic rx_ready_o,
  input wire logic [1:0] rx_chan_i,
  input wire logic [7:0] rx_data_i,
  input wire logic rx_ad_flag_i,
  input wire logic [2:0] rx_err_i,
  // push into the receive_queue of the named channel
  output logic rxq_push_o,
  input wire logic rxq_ready_i,
  output logic [1:0] rxq_chan_o,
  output logic [7:0] rxq_data_o,
  output logic [3:0] rxq_status_o,
  output logic receive_ready_flag_o,
  // queue reads and interrupt context
  input wire logic [NCH-1:0] chan_read_i,
  input wire logic global_read_i,
  input wire logic [1:0] int_ctx_chan_i,
  input wire logic [NCH-1:0] bit_tick_i,
  // watchdog control and status
  input wire logic [NCH-1:0] rx_timeout_enable_i,
  input wire logic [NCH-1:0] rx_timeout_control_i,
  input wire logic [NCH-1:0] interrupt_mask_6_i,
  output logic [NCH-1:0] interrupt_status_6_o,
  output logic receiver_only_o,
  input wire logic [6:0] interrupt_threshold_i,
  output logic [6:0] threshold_o,
  input wire logic [NCH-1:0] rx_bid_en_i,
  input wire logic [NCH-1:0][3:0] rx_count_i,
  output logic rx_win_valid_o,
  output logic [1:0] rx_win_chan_o,
  // wake-up configuration and host commands
  input wire logic [NCH-1:0][7:0] mode_control_0_i,
  input wire logic [NCH-1:0][7:0] mode_control_1_i,
  input wire logic [NCH-1:0][7:0] station_address_char_i,
  input wire logic [NCH-1:0][2:0] address_event_bid_level_i,
  input wire logic [NCH-1:0] interrupt_mask_5_i,
  input wire logic [NCH-1:0] rx_enable_cmd_i,
  input wire logic [NCH-1:0] rx_disable_cmd_i,
  input wire logic [NCH-1:0] rx_reset_i,
  input wire logic [NCH-1:0] addr_clear_i,
  output logic [NCH-1:0] interrupt_status_5_o,
  output logic [NCH-1:0] addr_irq_o,
  output logic [NCH-1:0][9:0] addr_bid_o,
  output logic [NCH-1:0] rx_active_o,
  output logic [NCH-1:0] tx_ad_flag_o
);

  // wake-up select decode, used by the filter and the activity outputs
  function automatic logic uwd_is_wake(input logic [7:0] m1);
    uwd_is_wake = m1[M1_WAKE_HI:M1_WAKE_LO] == WAKE_SEL;
  endfunction : uwd_is_wake

  uwd_state_t s_q;
  uwd_state_t s_d;
  logic f_valid;
  logic pop;
  logic [WORD_W-1:0] f_word;
  logic [NCH-1:0] wd_irq;

  // four word queue absorbs bursts while the receive_queue stalls
  uwd_fifo #(.W(WORD_W), .D(FIFO_DEPTH)) u_fifo (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .in_valid_i(rx_valid_i),
    .in_ready_o(rx_ready_o),
    .in_data_i({rx_chan_i, rx_data_i, rx_ad_flag_i, rx_err_i}),
    .out_valid_o(f_valid),
    .out_ready_i(rxq_ready_i),
    .out_data_o(f_word)
  );

  // one character leaves the queue per cycle while the downstream accepts
  assign pop = f_valid & rxq_ready_i;

  // next-state logic: host commands, wake-up filter, watchdogs, arbiter
  always_comb begin
    logic [1:0] c;
    logic ad;
    logic keep;
    logic match;
    logic auto;
    logic restart;
    logic [3:0] best;
    c = f_word[W_CHAN +: 2];
    ad = f_word[W_AD];
    keep = 1'b0;
    match = 1'b0;
    auto = 1'b0;
    restart = 1'b0;
    best = 4'h0;
    s_d = s_q;
    s_d.push = 1'b0;
    // host commands first so a character event in the same cycle wins
    for (int g = 0; g < NCH; g++) begin
      if (rx_reset_i[g]) begin
        s_d.rx_en[g] = 1'b0;
        s_d.addr_ev[g] = 1'b0;
      end else begin
        if (rx_disable_cmd_i[g]) begin
          s_d.rx_en[g] = 1'b0;
        end else if (rx_enable_cmd_i[g]) begin
          s_d.rx_en[g] = 1'b1;
        end
        if (addr_clear_i[g]) begin
          s_d.addr_ev[g] = 1'b0;
        end
      end
    end
    // wake-up filter; outside wake-up every character is kept
    if (pop) begin
      keep = 1'b1;
      if (uwd_is_wake(mode_control_1_i[c])) begin
        auto = mode_control_0_i[c][M0_WAKE] | mode_control_0_i[c][M0_DOZE];
        match = f_word[W_DATA +: 8] == station_address_char_i[c];
        if (ad) begin
          // host mode stores every address, auto modes follow the push bit
          keep = auto ? mode_control_0_i[c][M0_ADDR_PUSH] : 1'b1;
          if (auto && match) begin
            s_d.addr_ev[c] = 1'b1;
          end
          if (mode_control_0_i[c][M0_WAKE] && match) begin
            s_d.rx_en[c] = 1'b1;
          end else if (mode_control_0_i[c][M0_DOZE] && !match) begin
            s_d.rx_en[c] = 1'b0;
          end
        end else begin
          keep = s_q.rx_en[c];
        end
      end
      s_d.push = keep;
      s_d.chan = c;
      s_d.data = f_word[W_DATA +: 8];
      // flag slot doubles as parity error outside wake-up
      s_d.stat = {f_word[W_ERR +: 3], ad};
    end
    // watchdogs: reads and pushes restart, timeout holds until serviced
    for (int g = 0; g < NCH; g++) begin
      restart = (s_d.push && s_d.chan == 2'(g)) || chan_read_i[g]
        || (global_read_i && int_ctx_chan_i == 2'(g));
      if (!(rx_timeout_enable_i[g] && rx_timeout_control_i[g])) begin
        s_d.cnt[g] = CNT_RST;
        s_d.bark[g] = 1'b0;
      end else if (restart) begin
        s_d.cnt[g] = CNT_RST;
        s_d.bark[g] = 1'b0;
      end else if (bit_tick_i[g] && !s_q.bark[g]) begin
        s_d.cnt[g] = CNT_W'(s_q.cnt[g] + 1'b1);
        if (s_q.cnt[g] == WD_LIMIT - 1'b1) begin
          s_d.bark[g] = 1'b1;
        end
      end
    end
    // receiver-only bid: fullest enabled receiver, later channel wins ties
    s_d.win_v = 1'b0;
    s_d.win = 2'h0;
    if (|(s_q.bark & interrupt_mask_6_i)) begin
      for (int g = 0; g < NCH; g++) begin
        if (rx_bid_en_i[g] && (!s_d.win_v || rx_count_i[g] >= best)) begin
          best = rx_count_i[g];
          s_d.win = 2'(g);
          s_d.win_v = 1'b1;
        end
      end
    end
  end

  // single registered state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q <= STATE_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // queue push outputs straight from flops
  assign rxq_push_o = s_q.push;
  assign receive_ready_flag_o = s_q.push;
  assign rxq_chan_o = s_q.chan;
  assign rxq_data_o = s_q.data;
  assign rxq_status_o = s_q.stat;
  assign rx_win_valid_o = s_q.win_v;
  assign rx_win_chan_o = s_q.win;

  // timeout status and arbiter mode; threshold forced to zero while a timeout with mask bit 6 set is pending
  assign wd_irq = s_q.bark & interrupt_mask_6_i;
  assign interrupt_status_6_o = s_q.bark;
  assign receiver_only_o = |wd_irq;
  assign threshold_o = receiver_only_o ? 7'h00 : interrupt_threshold_i;

  // per-channel wake-up outputs and address event bids
  genvar gc;
  generate
    for (gc = 0; gc < NCH; gc++) begin : g_ch
      assign rx_active_o[gc] = s_q.rx_en[gc] | uwd_is_wake(mode_control_1_i[gc]);
      assign tx_ad_flag_o[gc] = mode_control_1_i[gc][M1_TXAD];
      assign interrupt_status_5_o[gc] = s_q.addr_ev[gc];
      assign addr_irq_o[gc] = s_q.addr_ev[gc] & interrupt_mask_5_i[gc];
      assign addr_bid_o[gc] = {address_event_bid_level_i[gc], ADDR_CODE, 3'(gc)};
    end
  endgenerate

  // checks
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  sequence host_wake_drop_s;
    pop && uwd_is_wake(mode_control_1_i[f_word[W_CHAN +: 2]]) && !f_word[W_AD]
      && !s_q.rx_en[f_word[W_CHAN +: 2]];
  endsequence

  sequence auto_wake_match_s;
    pop && uwd_is_wake(mode_control_1_i[f_word[W_CHAN +: 2]]) && f_word[W_AD]
      && mode_control_0_i[f_word[W_CHAN +: 2]][M0_WAKE]
      && f_word[W_DATA +: 8] == station_address_char_i[f_word[W_CHAN +: 2]];
  endsequence

  drop_data_a: assert property (host_wake_drop_s |=> !rxq_push_o)
    else $error("data char stored by disabled wake-up receiver");
  auto_wake_a: assert property (auto_wake_match_s ##1 !(|rx_disable_cmd_i) && !(|rx_reset_i)
    |-> s_q.rx_en[$past(f_word[W_CHAN +: 2])])
    else $error("matching address did not enable receiver");
  thresh_zero_a: assert property (receiver_only_o |-> threshold_o == 7'h00)
    else $error("threshold not ignored in receiver-only mode");
  status_flag_a: assert property (pop |=> !rxq_push_o || rxq_status_o[0] == $past(f_word[W_AD]))
    else $error("flag slot does not carry received flag");

  generate
    for (gc = 0; gc < NCH; gc++) begin : g_chk
      bark_count_a: assert property ($rose(s_q.bark[gc]) |-> s_q.cnt[gc] == WD_LIMIT)
        else $error("timeout not at 64 ticks");
      read_restart_a: assert property (chan_read_i[gc] |=> s_q.cnt[gc] == CNT_RST && !s_q.bark[gc])
        else $error("channel read did not restart watchdog");
      other_ctx_a: assert property (global_read_i && int_ctx_chan_i != 2'(gc) && !chan_read_i[gc]
        && s_q.cnt[gc] != CNT_RST && rx_timeout_enable_i[gc] && rx_timeout_control_i[gc]
        && !(s_d.push && s_d.chan == 2'(gc)) |=> s_q.cnt[gc] != CNT_RST)
        else $error("global read restarted another channel");
      wd_off_a: assert property (!rx_timeout_control_i[gc] |=> s_q.cnt[gc] == CNT_RST && !s_q.bark[gc])
        else $error("disabled watchdog still counting");
      mask6_a: assert property (s_q.bark[gc] && interrupt_mask_6_i[gc] |-> receiver_only_o)
        else $error("masked-in timeout did not reach arbiter");
    end
  endgenerate

endmodule : uwd_rx_watch
